// [rtl/dio_port.sv]
// pattern port: group direction, tristate, packing, aux lines, indicator
`timescale 1ns/1ps
module dio_port (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    // configuration
    input  wire logic [3:0]  i_group_dir,      // 1 = output, per group
    input  wire logic [1:0]  i_width_sel,      // sample width code
    input  wire logic [3:0]  i_group_sel,      // groups making up a sample
    input  wire logic [1:0]  i_level_sel,      // logic level code
    input  wire logic [23:0] i_aux_func,       // 3 bits per aux line
    input  wire logic        i_acq_en,         // acquisition running
    input  wire logic        i_in_dma,         // input dma active
    input  wire logic        i_out_dma,        // output dma active
    // sample strobe and output data
    input  wire logic        i_sample,         // one-cycle sample strobe
    input  wire logic [31:0] i_out_data,       // data to drive
    input  wire logic        i_out_valid,      // output data present
    // parallel lines
    input  wire logic [31:0] i_parallel_lines,
    output logic [31:0]      o_parallel_lines,
    output logic [31:0]      o_parallel_lines_oe,
    // aux lines
    input  wire logic [7:0]  i_aux_function_line,
    output logic [7:0]       o_aux_function_line,
    output logic [7:0]       o_aux_function_line_oe,
    input  wire logic [7:0]  i_aux_out,        // values for aux outputs
    output logic [7:0]       o_aux_in,         // synchronised aux inputs
    // packed word stream
    output logic [31:0]      o_pattern_input,
    output logic             o_pattern_valid,
    input  wire logic        i_pattern_ready,
    output logic             o_overflow,
    // level and indicator
    output logic [1:0]       o_level,
    output logic [1:0]       o_access_indicator,
    output logic [3:0]       o_group_dir
);
    // ****************************************************
    // input synchronisers
    // ****************************************************
    logic [31:0] pin_s1_r;   // first stage, read only by second
    logic [31:0] pin_s2_r;
    logic [31:0] pin_s3_r;
    logic [31:0] pin_r;      // accepted level
    logic [7:0]  aux_s1_r;
    logic [7:0]  aux_s2_r;
    logic [7:0]  aux_s3_r;
    logic [7:0]  aux_r;

    // three stages, change taken when stages two and three agree
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_s3_r <= '0;
            pin_r    <= '0;
            aux_s1_r <= '0;
            aux_s2_r <= '0;
            aux_s3_r <= '0;
            aux_r    <= '0;
        end else begin
            pin_s1_r <= i_parallel_lines;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            // stages that disagree keep the last accepted level
            pin_r    <= ((pin_s2_r ~^ pin_s3_r) & pin_s2_r) |
                        (~(pin_s2_r ~^ pin_s3_r) & pin_r);
            aux_s1_r <= i_aux_function_line;
            aux_s2_r <= aux_s1_r;
            aux_s3_r <= aux_s2_r;
            aux_r    <= (aux_s2_r == aux_s3_r) ? aux_s2_r : aux_r;
        end
    end

    // ****************************************************
    // group direction and tristate
    // ****************************************************
    logic [3:0] dir_r;      // applied direction
    logic [3:0] driven_r;   // group has received output data
    logic [3:0] oe_nxt;

    // direction per group
    // held while a sample is being packed so no sample mixes settings
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            dir_r <= dio_pkg::DIR_RESET;
        end else if (i_sample || !i_acq_en) begin
            dir_r <= i_group_dir;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            driven_r <= '0;
        end else begin
            driven_r <= dir_r & (driven_r | {4{i_out_valid}});
        end
    end

    always_comb begin
        oe_nxt = dir_r & driven_r;
    end

    // output lines registered, enable expanded to eight lines per group
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_parallel_lines    <= '0;
            o_parallel_lines_oe <= '0;
        end else begin
            for (int g = 0; g < dio_pkg::GROUPS; g++) begin
                o_parallel_lines_oe[g*8 +: 8] <= {8{oe_nxt[g]}};
                if (i_out_valid) begin
                    o_parallel_lines[g*8 +: 8] <= i_out_data[g*8 +: 8];
                end
            end
        end
    end

    // ****************************************************
    // sample gathering and packing
    // ****************************************************
    logic [31:0] sample;      // selected groups, lowest first
    logic [5:0]  samp_bits;   // bits per sample
    logic [31:0] acc_r;       // word under construction
    logic [5:0]  fill_r;      // bits already in acc_r
    logic [31:0] merged;
    logic [6:0]  total;
    logic        word_done;
    logic        f_ready;
    logic        f_valid;
    logic [31:0] f_data;

    always_comb begin
        logic [2:0] n;
        n      = 3'h0;
        sample = '0;
        for (int g = 0; g < dio_pkg::GROUPS; g++) begin
            if (i_group_sel[g] && !dir_r[g] && n <= {1'b0, i_width_sel}) begin
                sample[n*8 +: 8] = pin_r[g*8 +: 8];
                n = n + 3'h1;
            end
        end
        samp_bits = 6'({i_width_sel, 3'h0}) + 6'h08;
    end

    always_comb begin
        merged    = acc_r | (sample << fill_r);
        total     = 7'(fill_r) + 7'(samp_bits);
        word_done = (total >= 7'h20);
    end

    // accumulator; leftover bits of a 24-bit sample carry into next word
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            acc_r  <= '0;
            fill_r <= '0;
        end else if (!i_acq_en) begin
            acc_r  <= '0;
            fill_r <= '0;
        end else if (i_sample && f_ready) begin
            if (word_done) begin
                acc_r  <= (fill_r == 6'h00) ? '0 : sample >> (6'h20 - fill_r);
                fill_r <= 6'(total - 7'h20);
            end else begin
                acc_r  <= merged;
                fill_r <= 6'(total);
            end
        end
    end

    // samples lost while the fifo is full
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_overflow <= 1'b0;
        end else if (!i_acq_en) begin
            o_overflow <= 1'b0;
        end else if (i_sample && !f_ready) begin
            o_overflow <= 1'b1;
        end
    end

    dio_fifo #(
        .WIDTH (dio_pkg::WORD_W),
        .DEPTH (dio_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_data  (merged),
        .i_valid (i_acq_en && i_sample && word_done),
        .o_ready (f_ready),
        .o_data  (f_data),
        .o_valid (f_valid),
        .i_ready (!o_pattern_valid)  // stage loads whenever empty, so pop then
    );

    // output register stage keeps the stream from a flip-flop
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_pattern_input <= '0;
            o_pattern_valid <= 1'b0;
        end else if (!o_pattern_valid || i_pattern_ready) begin
            o_pattern_valid <= f_valid && !o_pattern_valid;
            if (f_valid && !o_pattern_valid) begin
                o_pattern_input <= f_data;
            end
        end
    end

    // ****************************************************
    // aux lines, level, indicator
    // ****************************************************
    // function sets direction
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_aux_function_line    <= '0;
            o_aux_function_line_oe <= '0;
            o_aux_in               <= '0;
        end else begin
            o_aux_in            <= aux_r;
            o_aux_function_line <= i_aux_out;
            for (int a = 0; a < dio_pkg::AUX_LINES; a++) begin
                case (i_aux_func[a*3 +: 3])
                    dio_pkg::AUX_SER_OUT,
                    dio_pkg::AUX_HSHAKE,
                    dio_pkg::AUX_EVT_OUT: o_aux_function_line_oe[a] <= 1'b1;
                    // bidirectional serial data driven only low
                    dio_pkg::AUX_SER_IO:  o_aux_function_line_oe[a] <= ~i_aux_out[a];
                    default:              o_aux_function_line_oe[a] <= 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_level <= dio_pkg::LEVEL_RESET;
        end else if (i_level_sel <= dio_pkg::LEVEL_3V3) begin
            o_level <= i_level_sel;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_access_indicator <= dio_pkg::IND_OFF;
        end else begin
            case ({i_in_dma, i_out_dma})
                2'h3:    o_access_indicator <= dio_pkg::IND_AMBER;
                2'h1:    o_access_indicator <= dio_pkg::IND_YELLOW;
                2'h2:    o_access_indicator <= dio_pkg::IND_RED;
                default: o_access_indicator <= dio_pkg::IND_OFF;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_group_dir <= dio_pkg::DIR_RESET;
        end else begin
            o_group_dir <= dir_r;
        end
    end
endmodule

// [rtl/dio_pkg.sv]
// constants shared by the pattern port logic, its checker and its bench
//
// Overview of operation
// - four independent eight-line groups, own direction each
// - reset leaves every group as input
// - new output group stays tristated until data
// - sample width 8/16/24/32 from chosen groups
// - acquired data always leaves as 32-bit words
// - one logic level applies to all lines
// - eight aux lines, function sets their direction
// - indicator yellow output-only, amber both DMA
package dio_pkg;
    // ****************************************************
    // port geometry
    // ****************************************************
    localparam int GROUPS     = 4;
    localparam int GROUP_W    = 8;
    localparam int LINES      = 32;
    localparam int WORD_W     = 32;
    localparam int AUX_LINES  = 8;
    localparam int FIFO_DEPTH = 8;
    // ****************************************************
    // sample width codes (number of groups minus one)
    // ****************************************************
    localparam logic [1:0] WIDTH_8  = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;
    localparam logic [1:0] WIDTH_24 = 2'h2;
    localparam logic [1:0] WIDTH_32 = 2'h3;
    // ****************************************************
    // logic level codes
    // ****************************************************
    localparam logic [1:0] LEVEL_1V8 = 2'h0;
    localparam logic [1:0] LEVEL_2V5 = 2'h1;
    localparam logic [1:0] LEVEL_3V3 = 2'h2;
    // ****************************************************
    // aux line function codes
    // ****************************************************
    localparam logic [2:0] AUX_OFF     = 3'h0;
    localparam logic [2:0] AUX_SER_OUT = 3'h1;
    localparam logic [2:0] AUX_SER_IO  = 3'h2;
    localparam logic [2:0] AUX_SER_IN  = 3'h3;
    localparam logic [2:0] AUX_HSHAKE  = 3'h4;
    localparam logic [2:0] AUX_TRIG_IN = 3'h5;
    localparam logic [2:0] AUX_EVT_OUT = 3'h6;
    localparam logic [2:0] AUX_CLK_IN  = 3'h7;
    localparam logic [2:0] AUX_CLK_OUT = 3'h7;
    // ****************************************************
    // indicator colour codes and reset values
    // ****************************************************
    localparam logic [1:0] IND_OFF    = 2'h0;
    localparam logic [1:0] IND_RED    = 2'h1;
    localparam logic [1:0] IND_YELLOW = 2'h2;
    localparam logic [1:0] IND_AMBER  = 2'h3;
    localparam logic [3:0] DIR_RESET  = 4'h0;
    localparam logic [1:0] LEVEL_RESET = 2'h2;
endpackage

// [rtl/dio_fifo.sv]
// small flip-flop fifo carrying packed words toward the host side
`timescale 1ns/1ps
module dio_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_valid,
    output logic                  o_ready,
    output logic [WIDTH-1:0]      o_data,
    output logic                  o_valid,
    input  wire logic             i_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];  // storage
    logic [AW-1:0]    wr_r;           // write index
    logic [AW-1:0]    rd_r;           // read index
    logic [AW:0]      cnt_r;          // fill level
    logic             push;
    logic             pop;

    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;
    assign o_ready = (cnt_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign o_valid = (cnt_r != '0);
    assign o_data  = mem_r[rd_r];

    // storage write, no reset needed on data
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_r[wr_r] <= i_data;
        end
    end

    // pointers and fill level
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            end
            // simultaneous push and pop keep the level
            if (push && !pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule

// [bench/dio_port_props.sv]
// checker for the pattern port top level
`timescale 1ns/1ps
module dio_port_chk (
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_acq_en,
    input wire logic        i_sample,
    input wire logic        i_out_valid,
    input wire logic        i_in_dma,
    input wire logic        i_out_dma,
    input wire logic [1:0]  i_level_sel,
    input wire logic [23:0] i_aux_func,
    input wire logic        i_pattern_ready,
    input wire logic [3:0]  o_group_dir,
    input wire logic [31:0] o_parallel_lines_oe,
    input wire logic [31:0] o_pattern_input,
    input wire logic        o_pattern_valid,
    input wire logic        o_overflow,
    input wire logic [1:0]  o_level,
    input wire logic [1:0]  o_access_indicator,
    input wire logic [7:0]  o_aux_function_line_oe
);
    // ****************************************************
    // assertions
    // ****************************************************
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    rst_clear_a: assert property ($rose(i_rstn) |-> o_group_dir == 4'h0
        && o_parallel_lines_oe == 32'h0) else $error("reset left lines driven");
    dir_edge_a: assert property ($past(i_rstn, 2) && o_group_dir != $past(o_group_dir)
        |-> $past(i_sample, 2) || !$past(i_acq_en, 2)) else $error("direction moved mid sample");
    out_tri_a: assert property ($rose(o_group_dir[0])
        |-> o_parallel_lines_oe[7:0] == 8'h0) else $error("new output group not tristated");
    oe_cause_a: assert property ($rose(|o_parallel_lines_oe) |-> $past(i_out_valid)
        || $past(i_out_valid, 2) || $past(i_out_valid, 3)) else $error("drivers on without data");
    led_map_a: assert property ($past(i_rstn) |-> o_access_indicator
        == {$past(i_out_dma), $past(i_in_dma)}) else $error("indicator colour wrong");
    level_set_a: assert property ($past(i_rstn) && $past(i_level_sel) != 2'h3
        |-> o_level == $past(i_level_sel)) else $error("level not applied");
    word_hold_a: assert property (o_pattern_valid && !i_pattern_ready
        |=> o_pattern_valid && $stable(o_pattern_input)) else $error("word dropped");
    word_gap_a: assert property (o_pattern_valid && i_pattern_ready
        |=> !o_pattern_valid) else $error("no bubble after word");
    ovf_stick_a: assert property (o_overflow && i_acq_en |=> o_overflow)
        else $error("overflow lost");
    aux_in_a: assert property ((i_aux_func[2:0] == dio_pkg::AUX_TRIG_IN)[*2]
        |-> !o_aux_function_line_oe[0]) else $error("input aux driven");
    aux_out_a: assert property ((i_aux_func[2:0] == dio_pkg::AUX_EVT_OUT)[*2]
        |-> o_aux_function_line_oe[0]) else $error("output aux not driven");
    // main scenarios reached
    cover property (o_overflow);
    cover property (o_pattern_valid && i_pattern_ready);
    cover property (o_access_indicator == dio_pkg::IND_AMBER);
endmodule
bind dio_port dio_port_chk dio_port_chk_inst (.*);

// [bench/lines_model.sv]
// far-side device: drives every line the port leaves released
`timescale 1ns/1ps
module lines_model (
    input  wire logic [31:0] i_drv,
    input  wire logic [31:0] i_oe,
    input  wire logic [7:0]  i_aux_drv,
    input  wire logic [7:0]  i_aux_oe,
    input  wire logic [31:0] i_pat,
    input  wire logic [7:0]  i_aux_pat,
    output logic [31:0]      o_lines,
    output logic [7:0]       o_aux
);
    // per line: port wins where it drives, device elsewhere
    assign o_lines = (i_drv & i_oe) | (i_pat & ~i_oe);
    // aux wires resolved the same way
    assign o_aux = (i_aux_drv & i_aux_oe) | (i_aux_pat & ~i_aux_oe);
endmodule

// [bench/tb_top.sv]
// self-checking bench for the pattern port
`timescale 1ns/1ps
`define CHK(nm, ex, ac) begin tests_run++; if ((ac) !== (ex)) begin error_cnt++; \
    $display("BAD %s exp %0h got %0h", nm, ex, ac); end end
module tb_top;
    logic i_clk = 0, i_rstn = 0, acq = 0, in_dma = 0, out_dma = 0, smp = 0, ov = 0, rdy = 1;
    logic [3:0] dir = 0, gsel = 4'hF;
    logic [1:0] wsel = 0, lsel = 2'h3;
    logic [23:0] func = 0;
    logic [31:0] od = 0, pat = 0, lines, drv, oe, word;
    logic [7:0] aout = 0, apat = 8'hFF, aux, adrv, aoe, ain;
    logic [3:0] gdir;
    logic [1:0] lvl, led;
    logic wvalid, ovf;
    logic [31:0] got[$];
    int error_cnt = 0, tests_run = 0;
    always #10 i_clk = ~i_clk;
    dio_port dio_port_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_group_dir(dir),
        .i_width_sel(wsel), .i_group_sel(gsel), .i_level_sel(lsel), .i_aux_func(func),
        .i_acq_en(acq), .i_in_dma(in_dma), .i_out_dma(out_dma), .i_sample(smp),
        .i_out_data(od), .i_out_valid(ov), .i_parallel_lines(lines), .o_parallel_lines(drv),
        .o_parallel_lines_oe(oe), .i_aux_function_line(aux), .o_aux_function_line(adrv),
        .o_aux_function_line_oe(aoe), .i_aux_out(aout), .o_aux_in(ain),
        .o_pattern_input(word), .o_pattern_valid(wvalid), .i_pattern_ready(rdy),
        .o_overflow(ovf), .o_level(lvl), .o_access_indicator(led), .o_group_dir(gdir));
    lines_model lines_model_inst (.i_drv(drv), .i_oe(oe), .i_aux_drv(adrv),
        .i_aux_oe(aoe), .i_pat(pat), .i_aux_pat(apat), .o_lines(lines), .o_aux(aux));
    // collect every word the host side accepts
    always @(posedge i_clk) if (wvalid && rdy) got.push_back(word);
    task tick(input int n); repeat (n) @(posedge i_clk); endtask
    // pins need four edges to reach the sampler, so settle first
    task samp(input logic [31:0] v);
        pat <= v; tick(6); smp <= 1; tick(1); smp <= 0;
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // three words per width, packed from the low end
    task run_width(input logic [1:0] w);
        int nb; logic [95:0] acc; logic [31:0] s, m;
        nb = (w + 1) * 8; acc = '0; got.delete();
        wsel <= w; gsel <= 4'hF >> (3 - w); tick(2);
        m = (nb == 32) ? 32'hFFFFFFFF : (32'h1 << nb) - 1;
        for (int k = 0; k < 96 / nb; k++) begin
            s = 32'h04030201 * (k + 1); samp(s);
            acc = acc | ({64'h0, s & m} << (k * nb));
        end
        tick(10);
        `CHK("word count", 3, got.size())
        for (int i = 0; i < 3; i++) `CHK("packed word", acc[i*32 +: 32], got[i])
        $display("width code %0d done", w);
    endtask
    initial begin
        tick(20); i_rstn <= 1; tick(2);
        `CHK("reset dir", 4'h0, gdir)
        `CHK("reset oe", 32'h0, oe)
        `CHK("reset level", dio_pkg::LEVEL_RESET, lvl)
        acq <= 1;
        for (int w = 0; w < 4; w++) run_width(w[1:0]);
        dir <= 4'h5; tick(3);
        `CHK("dir before sample", 4'h0, gdir)
        smp <= 1; tick(1); smp <= 0; tick(2);
        `CHK("dir applied", 4'h5, gdir)
        `CHK("tristate first", 32'h0, oe)
        od <= 32'hA5C35A3C; ov <= 1; tick(1); ov <= 0; tick(3);
        `CHK("driven groups", 32'h00FF00FF, oe)
        `CHK("driven data", 32'h00C3003C, drv & oe)
        tick(8); got.delete(); samp(32'h44332211); tick(8);
        `CHK("input groups only", 32'h00004422, got[0])
        dir <= 4'h0; acq <= 0; tick(4);
        `CHK("dir back", 4'h0, gdir)
        $display("direction test done");
        acq <= 1; rdy <= 0; tick(2); got.delete();
        for (int k = 0; k < 12; k++) samp(32'h100 + k);
        `CHK("overflow", 1'b1, ovf)
        rdy <= 1; tick(40);
        `CHK("first drained", 32'h100, got[0])
        `CHK("second drained", 32'h101, got[1])
        `CHK("fifo held eight", 1'b1, got.size() >= 8)
        `CHK("drained", 1'b0, wvalid)
        acq <= 0; tick(2);
        `CHK("overflow cleared", 1'b0, ovf)
        $display("fifo test done");
        for (int l = 0; l < 4; l++) begin
            lsel <= l[1:0]; tick(2);
            `CHK("level", (l == 3) ? 2'h2 : l[1:0], lvl)
        end
        for (int k = 0; k < 4; k++) begin
            {out_dma, in_dma} <= k[1:0]; tick(2);
            `CHK("indicator", k[1:0], led)
        end
        aout <= 8'h5A;
        for (int f = 0; f < 8; f++) begin
            func <= {21'h0, f[2:0]}; tick(8);
            `CHK("aux drive", f == 1 || f == 2 || f == 4 || f == 6, aoe[0])
            if (f == 4) `CHK("aux loop back", 1'b0, ain[0])
            if (f == 5) `CHK("aux input", 1'b1, ain[0])
        end
        `CHK("aux out value", 8'h5A, adrv)
        $display("level indicator aux done");
        summarize();
    end
    // hang guard, far beyond the few hundred cycles used
    initial begin
        tick(20000); error_cnt++; summarize();
    end
endmodule
